// *** hw/thmc_crc.sv ***
// running 16-bit HDLC check value, bits taken lsb first;
// assumes one step request per octet, never together with init.
module thmc_crc
  import thmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // octet stream
  thmc_crc_if.calc c
);
  function automatic logic [15:0] thmc_crc_byte(input logic [15:0] v,
                                                input logic [7:0] d);
    logic [15:0] r;
    r = v;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      c.crc <= CRC_INIT;
    end else if (c.init) begin
      c.crc <= CRC_INIT;
    end else if (c.step) begin
      c.crc <= thmc_crc_byte(c.crc, c.data);
    end
  end
endmodule

// *** hw/thmc_crc_if.sv ***
// carries the byte stream into the check-sequence generator and its
// running value back; both ends on sys_clk.
interface thmc_crc_if;
  logic init;
  logic step;
  logic [7:0] data;
  logic [15:0] crc;
  modport eng (output init, output step, output data, input crc);
  modport calc (input init, input step, input data, output crc);
endinterface

// *** hw/thmc_pkg.sv ***
// constants, register map and state codes of the transmit data-link
// message controller; assumes a single 20 MHz clock domain.
// Operation
// - checksum on appends check octets to every message frame; off, none.
// - checksum enable is ignored while bit-oriented signaling is selected.
// - signaling-type 0 sends bit-oriented message, 1 sends message frame.
// - written buffer-select picks buffer 0 or buffer 1 for transmission.
// - reading buffer-select returns next free buffer, at 0x600 or 0x700.
// - while a buffer is still in use, reads report the other buffer.
// - bit-oriented count gives repeats; then end-of-transfer irq and stop.
// - bit-oriented count of zero repeats forever, no end-of-transfer stop; the code ends the repeat once the other buffer is armed.
// - message-oriented count is frame length in octets from chosen buffer.
// - length includes address and control octets, excludes check octets.
// - with no frame pending, repeated 0x7E flag octets are sent.
package thmc_pkg;
  // ----------------------------------------------------------------
  // clock and link rate
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int DL_RATE_HZ = 4_000;
  localparam int BIT_DIV_DEF = CLK_HZ / DL_RATE_HZ;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int AW = 11;
  localparam logic [AW-1:0] OFS_CTRL = 11'h000;
  localparam logic [AW-1:0] OFS_COUNT = 11'h004;
  localparam logic [AW-1:0] OFS_STATUS = 11'h008;
  localparam logic [AW-1:0] OFS_MASK = 11'h00C;
  localparam logic [AW-1:0] OFS_BUF0 = 11'h600;
  localparam logic [AW-1:0] OFS_BUF1 = 11'h700;
  localparam int BUF_DEPTH = 128;
  localparam int BUF_TOP = 7;
  localparam int BUF_SEL = 8;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_SIGTYPE = 0;
  localparam int CTRL_FCS = 1;
  localparam int COUNT_SEL = 7;
  localparam int STAT_EOT = 0;
  localparam int STAT_FRAME = 1;
  localparam int STAT_W = 2;
  localparam int CNT_W = 7;
  // ----------------------------------------------------------------
  // line codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [7:0] CODE_LEAD = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CODE_BITS = 5'h10;
  typedef enum logic [2:0] {
    THMC_IDLE = 3'b000,
    THMC_DATA = 3'b001,
    THMC_FCS_HI = 3'b011,
    THMC_CLOSE = 3'b010,
    THMC_CODE = 3'b110
  } thmc_state_t;
endpackage

// *** hw/thmc_top.sv ***
// transmit side of one data-link HDLC controller: two message buffers,
// flag idle, message frames with optional check octets, repeated
// bit-oriented codewords; software over Avalon-MM with waitrequest.
// assumes the framer samples tx_dl_bit on each tx_dl_strobe.
module thmc_top
  import thmc_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIV_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave, byte address
  input wire logic [thmc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // data-link channel bit stream
  output logic tx_dl_bit,
  output logic tx_dl_strobe
);
  import thmc_pkg::*;
  localparam int DIVW = $clog2(BIT_DIV) + 1;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [2][BUF_DEPTH];
  logic signaling_type_select;
  logic checksum_append_enable;
  logic [CNT_W-1:0] tx_length_or_repeat_count;
  logic [CNT_W-1:0] job_cnt [2];
  logic [1:0] job_frame;
  logic [1:0] job_fcs;
  logic [1:0] pend;
  logic last_sel;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic acc;

  // link engine
  thmc_state_t state;
  thmc_state_t next_state;
  logic [15:0] sh;
  logic [4:0] left;
  logic stuff;
  logic [2:0] ones;
  logic [CNT_W-1:0] idx;
  logic [CNT_W-1:0] rep;
  logic cb;
  logic hd;
  logic pick;
  logic fin;
  logic fin_buf;
  logic fin_eot;
  logic [DIVW-1:0] div_cnt;
  logic tick;
  logic [15:0] ld_sh;
  logic [4:0] ld_len;
  logic ld_stuff;
  logic ld_start;
  logic ld_byte;
  logic ld_done;
  logic ld_rep;
  logic [STAT_W-1:0] ev;

  thmc_crc_if crc_bus ();
  thmc_crc u_crc (
    .sys_clk(sys_clk),
    .rst(rst),
    .c(crc_bus)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic thmc_is_buf(input logic [AW-1:0] a);
    return (a[AW-1:BUF_TOP] == OFS_BUF0[AW-1:BUF_TOP]) ||
           (a[AW-1:BUF_TOP] == OFS_BUF1[AW-1:BUF_TOP]);
  endfunction

  function automatic logic [15:0] thmc_code_word(input logic [7:0] d);
    // eight ones, then 0, six code bits, 0; lsb leaves first
    return {1'b0, d[5:0], 1'b0, CODE_LEAD};
  endfunction

  // next free buffer: the one not holding an unsent message
  function automatic logic thmc_free(input logic [1:0] p, input logic l);
    if (p[0] && !p[1]) begin
      return 1'b1;
    end else if (p[1] && !p[0]) begin
      return 1'b0;
    end else begin
      return ~l;
    end
  endfunction

  assign acc = (avs_read || avs_write) && !avs_waitrequest;

  // ----------------------------------------------------------------
  // bus slave: one wait state, then the access completes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (acc) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_write) begin
      avs_waitrequest <= 1'b0;
    end else if (avs_read) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      if (thmc_is_buf(avs_address)) begin
        for (int k = 0; k < 4; k++) begin
          avs_readdata[8*k +: 8] <=
            mem[avs_address[BUF_SEL]][{avs_address[6:2], 2'(k)}];
        end
      end else begin
        case (avs_address)
          OFS_CTRL: begin
            avs_readdata[CTRL_SIGTYPE] <= signaling_type_select;
            avs_readdata[CTRL_FCS] <= checksum_append_enable;
          end
          OFS_COUNT: begin
            avs_readdata[COUNT_SEL] <= thmc_free(pend, last_sel);
            avs_readdata[CNT_W-1:0] <= tx_length_or_repeat_count;
          end
          OFS_STATUS: avs_readdata[STAT_W-1:0] <= status;
          OFS_MASK: avs_readdata[STAT_W-1:0] <= mask;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers and message buffers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      signaling_type_select <= 1'b0;
      checksum_append_enable <= 1'b0;
      tx_length_or_repeat_count <= '0;
      mask <= '0;
      last_sel <= 1'b1;
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < BUF_DEPTH; i++) begin
          mem[b][i] <= 8'h00;
        end
      end
    end else if (acc && avs_write) begin
      if (thmc_is_buf(avs_address)) begin
        for (int k = 0; k < 4; k++) begin
          if (avs_byteenable[k]) begin
            mem[avs_address[BUF_SEL]][{avs_address[6:2], 2'(k)}] <=
              avs_writedata[8*k +: 8];
          end
        end
      end else begin
        case (avs_address)
          OFS_CTRL: begin
            if (avs_byteenable[0]) begin
              signaling_type_select <= avs_writedata[CTRL_SIGTYPE];
              checksum_append_enable <= avs_writedata[CTRL_FCS];
            end
          end
          OFS_COUNT: begin
            if (avs_byteenable[0]) begin
              tx_length_or_repeat_count <= avs_writedata[CNT_W-1:0];
              last_sel <= avs_writedata[COUNT_SEL];
            end
          end
          OFS_MASK: begin
            if (avs_byteenable[0]) begin
              mask <= avs_writedata[STAT_W-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // job per buffer, armed by a count write; a write naming a busy
  // buffer is dropped so the frame on the line stays intact
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend <= 2'b00;
      job_frame <= 2'b00;
      job_fcs <= 2'b00;
      job_cnt[0] <= '0;
      job_cnt[1] <= '0;
    end else begin
      if (fin) begin
        pend[fin_buf] <= 1'b0;
      end
      if (acc && avs_write && avs_address == OFS_COUNT &&
          avs_byteenable[0] && !pend[avs_writedata[COUNT_SEL]]) begin
        pend[avs_writedata[COUNT_SEL]] <= 1'b1;
        job_cnt[avs_writedata[COUNT_SEL]] <= avs_writedata[CNT_W-1:0];
        job_frame[avs_writedata[COUNT_SEL]] <= signaling_type_select;
        job_fcs[avs_writedata[COUNT_SEL]] <=
          checksum_append_enable && signaling_type_select;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      if (acc && avs_write && avs_address == OFS_STATUS &&
          avs_byteenable[0]) begin
        status <= (status & ~avs_writedata[STAT_W-1:0]) | ev;
      end else begin
        status <= status | ev;
      end
      irq <= |(status & mask);
    end
  end

  always_comb begin
    ev = '0;
    ev[STAT_EOT] = fin && fin_eot;
    ev[STAT_FRAME] = fin && !fin_eot && job_frame[fin_buf];
  end

  // ----------------------------------------------------------------
  // bit-rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == DIVW'(BIT_DIV - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // octet loader: decides the next unit once the shifter runs dry
  // ----------------------------------------------------------------
  assign pick = pend[hd] ? hd : ~hd;

  always_comb begin
    next_state = state;
    ld_sh = {8'h00, FLAG};
    ld_len = BYTE_BITS;
    ld_stuff = 1'b0;
    ld_start = 1'b0;
    ld_byte = 1'b0;
    ld_done = 1'b0;
    ld_rep = 1'b0;
    case (state)
      THMC_IDLE: begin
        if (|pend) begin
          ld_start = 1'b1;
          if (job_frame[pick]) begin
            next_state = THMC_DATA;
          end else begin
            ld_sh = thmc_code_word(mem[pick][0]);
            ld_len = CODE_BITS;
            next_state = THMC_CODE;
          end
        end
      end
      THMC_DATA: begin
        if (idx == job_cnt[cb]) begin
          if (job_fcs[cb]) begin
            ld_sh = {8'h00, ~crc_bus.crc[7:0]};
            ld_stuff = 1'b1;
            next_state = THMC_FCS_HI;
          end else begin
            ld_done = 1'b1;
            next_state = THMC_IDLE;
          end
        end else begin
          ld_sh = {8'h00, mem[cb][idx]};
          ld_stuff = 1'b1;
          ld_byte = 1'b1;
        end
      end
      THMC_FCS_HI: begin
        ld_sh = {8'h00, ~crc_bus.crc[15:8]};
        ld_stuff = 1'b1;
        next_state = THMC_CLOSE;
      end
      THMC_CLOSE: begin
        ld_done = 1'b1;
        next_state = THMC_IDLE;
      end
      THMC_CODE: begin
        // endless repeat yields only to a newly armed buffer
        if (~|job_cnt[cb] ? pend[~cb] : rep == job_cnt[cb]) begin
          ld_done = 1'b1;
          next_state = THMC_IDLE;
        end else begin
          ld_sh = thmc_code_word(mem[cb][0]);
          ld_len = CODE_BITS;
          ld_rep = 1'b1;
        end
      end
      default: next_state = THMC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // link engine: shift out lsb first, zero after five ones in frames
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= THMC_IDLE;
      sh <= 16'h0000;
      left <= 5'h00;
      stuff <= 1'b0;
      ones <= 3'h0;
      idx <= '0;
      rep <= '0;
      cb <= 1'b0;
      hd <= 1'b0;
      fin <= 1'b0;
      fin_buf <= 1'b0;
      fin_eot <= 1'b0;
      crc_bus.init <= 1'b0;
      crc_bus.step <= 1'b0;
      crc_bus.data <= 8'h00;
      tx_dl_bit <= 1'b1;
      tx_dl_strobe <= 1'b0;
    end else begin
      fin <= 1'b0;
      crc_bus.init <= 1'b0;
      crc_bus.step <= 1'b0;
      tx_dl_strobe <= tick;
      if (tick) begin
        if (ones == STUFF_RUN) begin
          tx_dl_bit <= 1'b0;
          ones <= 3'h0;
        end else begin
          tx_dl_bit <= sh[0];
          sh <= sh >> 1;
          left <= left - 1'b1;
          ones <= (stuff && sh[0]) ? ones + 1'b1 : 3'h0;
        end
      end else if (left == 5'h00) begin
        // divider of two or more leaves a free cycle for this load
        state <= next_state;
        sh <= ld_sh;
        left <= ld_len;
        stuff <= ld_stuff;
        if (ld_start) begin
          cb <= pick;
          hd <= ~pick;
          idx <= '0;
          rep <= CNT_W'(1);
          crc_bus.init <= 1'b1;
        end
        if (ld_byte) begin
          idx <= idx + 1'b1;
          crc_bus.step <= 1'b1;
          crc_bus.data <= mem[cb][idx];
        end
        if (ld_rep) begin
          rep <= rep + 1'b1;
        end
        if (ld_done) begin
          fin <= 1'b1;
          fin_buf <= cb;
          fin_eot <= (state == THMC_CODE) && (job_cnt[cb] != '0);
        end
      end
    end
  end
endmodule

// *** sim/thmc_asserts.sv ***
// checker for the transmit data-link message controller top ports
// bound onto thmc_top; one clock domain, reset active high
module thmc_asserts
  import thmc_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIV_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic [thmc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // interrupt and line
  input wire logic irq,
  input wire logic tx_dl_bit,
  input wire logic tx_dl_strobe
);
  import thmc_pkg::*;
  int gap;
  int ones;
  logic seen;
  logic req;
  logic mapped;
  assign req = avs_read || avs_write;
  // misaligned register offsets left out: decode width is the design's
  assign mapped = (avs_address[1:0] != 2'h0) || (avs_address[10:4] == 7'h00)
    || (avs_address[10:7] == 4'hC) || (avs_address[10:7] == 4'hE);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // line bookkeeping
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap <= 0;
      seen <= 1'b0;
    end else if (tx_dl_strobe) begin
      gap <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ones <= 0;
    end else if (tx_dl_strobe) begin
      ones <= tx_dl_bit ? ones + 1 : 0;
    end
  end
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  wait_one_a: assert property (req && avs_waitrequest |=> s_answer)
    else $error("bus access without a single answer cycle");
  idle_wait_a: assert property (!req |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  rdata_hold_a: assert property ($changed(avs_readdata) |->
    avs_read && !avs_waitrequest)
    else $error("read data moved outside a read answer");
  unmapped_rd_a: assert property (avs_read && !avs_waitrequest && !mapped
    |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero");
  strobe_gap_a: assert property (tx_dl_strobe && seen |->
    gap == BIT_DIV - 1)
    else $error("line strobe spacing wrong");
  gap_bound_a: assert property (gap <= BIT_DIV + 1)
    else $error("line strobe missing");
  bit_hold_a: assert property (!tx_dl_strobe |-> $stable(tx_dl_bit))
    else $error("line bit changed without strobe");
  ones_run_a: assert property (ones <= 8)
    else $error("run of ones too long on line");
  irq_fall_a: assert property ($fell(irq) |->
    $past(avs_write && !avs_waitrequest, 2)
    || $past(avs_write && !avs_waitrequest, 1))
    else $error("interrupt dropped without a register write");
endmodule
bind thmc_top thmc_asserts #(.BIT_DIV(BIT_DIV)) u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq),
  .tx_dl_bit(tx_dl_bit),
  .tx_dl_strobe(tx_dl_strobe)
);

// *** sim/thmc_partner.sv ***
// remote terminal: receives the data-link bit stream, counts flags,
// frames and repeated bit-oriented words; assumes bits lsb first
module thmc_partner (
  // line
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_dl_bit,
  input wire logic tx_dl_strobe,
  // observations
  output int frames,
  output int flen,
  output int nbos,
  output int nflag,
  output logic [7:0] fbuf [0:15]
);
  logic [15:0] sh;
  logic [7:0] acc [0:15];
  int run;
  int cnt;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {frames, flen, nbos, nflag, run, cnt} = '0;
      sh = 16'h0;
    end else if (tx_dl_strobe) begin
      sh = {tx_dl_bit, sh[15:1]};
      if (sh[7:0] == 8'hFF && !sh[8] && !sh[15]) nbos++;
      if (sh[15:8] == 8'h7E) begin
        nflag++;
        // frame length excludes the seven flag bits already taken
        if (cnt >= 15 && cnt < 136) begin
          flen = (cnt - 7) / 8;
          fbuf = acc;
          frames++;
        end
        cnt = 0;
        run = 0;
      end else if (run == 5 && !tx_dl_bit) begin
        run = 0;
      end else begin
        if (cnt < 128) acc[cnt / 8][cnt % 8] = tx_dl_bit;
        cnt++;
        run = tx_dl_bit ? run + 1 : 0;
        // long ones run spoils any frame until the next flag
        if (run >= 7) cnt = 1000;
      end
    end
  end
endmodule

// *** sim/thmc_tb_top.sv ***
// self-checking bench for thmc_top with the remote terminal model
// assumes BIT_DIV of 4 and the register map of thmc_pkg
module thmc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import thmc_pkg::*;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic tx_dl_bit, tx_dl_strobe;
  logic [AW-1:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [31:0] seed = 32'h61;
  logic [7:0] fbuf [0:15];
  logic [7:0] mem [0:15];
  int fails, checks_done, frames, flen, nbos, nflag, n, b0;
  thmc_top #(.BIT_DIV(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .tx_dl_bit(tx_dl_bit), .tx_dl_strobe(tx_dl_strobe));
  thmc_partner u_far (.sys_clk(sys_clk), .rst(rst), .tx_dl_bit(tx_dl_bit),
    .tx_dl_strobe(tx_dl_strobe), .frames(frames), .flen(flen),
    .nbos(nbos), .nflag(nflag), .fbuf(fbuf));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] fcs(input int len);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < len; i++)
      for (int k = 0; k < 8; k++)
        c = (c[0] ^ mem[i][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return ~c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [AW-1:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic fill(input logic b, input int len);
    for (int i = 0; i < len; i++) begin
      // bit 1 cleared keeps a codeword from looking like a flag
      mem[i] = 8'(rnd()) & 8'hFD;
      bus(1'b1, (b ? OFS_BUF1 : OFS_BUF0) + AW'(i), {4{mem[i]}},
        4'h1 << (i % 4));
    end
  endtask
  task automatic irq_clear(input int bitn);
    rd(OFS_STATUS);
    chk(32'(q[bitn]), 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_STATUS, 32'h1 << bitn);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic send_frame(input logic b, input logic fe);
    int f0, len;
    len = int'(rnd() % 12) + 1;
    f0 = frames;
    fill(b, len);
    wr(OFS_CTRL, {30'h0, fe, 1'b1});
    rd(OFS_COUNT);
    chk(32'(q[7]), 32'(b));
    wr(OFS_COUNT, {24'h0, b, 7'(len)});
    rd(OFS_COUNT);
    chk(32'(q[7]), 32'(!b));
    while (frames == f0) begin
      @(negedge sys_clk);
    end
    chk(32'(flen), 32'(len + (fe ? 2 : 0)));
    for (int i = 0; i < len; i++) chk(32'(fbuf[i]), 32'(mem[i]));
    if (fe) chk({16'h0, fbuf[len + 1], fbuf[len]}, 32'(fcs(len)));
    irq_clear(STAT_FRAME);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst, avs_read, avs_write} = 3'b100;
    avs_address = '0;
    avs_byteenable = 4'hF;
    avs_writedata = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_CTRL);
    chk(q, 32'h0);
    rd(OFS_COUNT);
    chk(q, 32'h0);
    rd(OFS_STATUS);
    chk(q, 32'h0);
    wr(11'h010, 32'hFFFFFFFF);
    rd(11'h010);
    chk(q, 32'h0);
    wr(OFS_MASK, 32'h3);
    rd(OFS_MASK);
    chk(q, 32'h3);
    repeat (300) @(negedge sys_clk);
    chk(32'(nflag >= 8), 32'h1);
    chk(32'(frames), 32'h0);
    send_frame(1'b0, 1'b1);
    send_frame(1'b1, 1'b0);
    n = int'(rnd() % 4) + 1;
    b0 = nbos;
    wr(OFS_CTRL, 32'h2);
    fill(1'b0, 1);
    wr(OFS_COUNT, 32'(n));
    do rd(OFS_STATUS); while (q[STAT_EOT] !== 1'b1 && nbos - b0 < 9);
    repeat (200) @(negedge sys_clk);
    chk(32'(nbos - b0), 32'(n));
    irq_clear(STAT_EOT);
    wr(OFS_CTRL, 32'h0);
    fill(1'b1, 1);
    b0 = nbos;
    wr(OFS_COUNT, 32'h80);
    repeat (600) @(negedge sys_clk);
    chk(32'(nbos - b0 >= 8), 32'h1);
    rd(OFS_STATUS);
    chk(32'(q[STAT_EOT]), 32'h0);
    send_frame(1'b0, 1'b0);
    report_and_stop();
  end
endmodule
